// ---- include/cmf_pkg.sv ----
package cmf_pkg;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG_A = 8'h04;
  localparam logic [7:0] OFS_CFG_B = 8'h08;
  localparam logic [7:0] OFS_OCAL_A = 8'h0C;
  localparam logic [7:0] OFS_OCAL_B = 8'h10;
  localparam logic [7:0] OFS_GCAL_A = 8'h14;
  localparam logic [7:0] OFS_GCAL_B = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_SAMPLE = 8'h20;

  // Control fields
  localparam int CTRL_CLK_SRC_BIT = 0;
  localparam int CTRL_EN_A_BIT = 1;
  localparam int CTRL_EN_B_BIT = 2;
  localparam logic CLK_SRC_INTERNAL = 1'b0;

  // Per-section configuration fields
  localparam int CFG_W = 7;
  localparam int CFG_MUX_LSB = 0;
  localparam int CFG_GAIN_LSB = 2;
  localparam int CFG_OSR_LSB = 4;
  localparam logic [6:0] CFG_RST = 7'h00;

  // Status fields
  localparam int ST_CLK_SRC_BIT = 0;
  localparam int ST_SETTLED_LSB = 1;
  localparam int ST_OVERRUN_LSB = 3;
  localparam int ST_LEVEL_LSB = 8;

  // Sample word fields
  localparam int SMP_SECTION_BIT = 24;
  localparam int SMP_VALID_BIT = 31;

  typedef enum logic [1:0] {
    CMF_IN_DIRECT = 2'h0,
    CMF_IN_INVERTED = 2'h1,
    CMF_IN_SHORT = 2'h2,
    CMF_IN_TEST_DAC = 2'h3
  } cmf_input_t;

  typedef enum logic [1:0] {
    CMF_GAIN_4 = 2'h0,
    CMF_GAIN_8 = 2'h1,
    CMF_GAIN_16 = 2'h2,
    CMF_GAIN_32 = 2'h3
  } cmf_gain_t;

  // Datapath
  localparam int ACC_W = 41;
  localparam int SAMPLE_W = 24;
  localparam int OCAL_W = 24;
  localparam int GCAL_W = 16;
  localparam int PROD_W = 43;
  localparam int DEC_W = 13;
  localparam logic [3:0] OSR_LOG_MIN = 4'h6;
  localparam logic [5:0] NORM_SHIFT_MAX = 6'h15;
  localparam int NORM_DROP = 16;
  localparam int CAL_SHIFT = 16;
  localparam logic signed [17:0] GCAL_UNITY = 18'sh10000;
  localparam logic signed [42:0] CAL_ROUND = 43'sh0008000;
  localparam logic [1:0] SETTLE_PERIODS = 2'h3;
  localparam logic [23:0] SAT_POS = 24'h7FFFFF;
  localparam logic [23:0] SAT_NEG = 24'h800000;
  localparam logic signed [42:0] CLIP_HI = 43'sh000007FFFFF;
  localparam logic signed [42:0] CLIP_LO = 43'sh7FFFF800000;

  // Sample FIFO
  localparam int FIFO_W = 25;
  localparam int FIFO_DEPTH = 8;

  // Clip a wide signed value to 24-bit full scale
  function automatic logic [23:0] cmf_clip(input logic signed [42:0] v);
    if (v > CLIP_HI) begin
      return SAT_POS;
    end else if (v < CLIP_LO) begin
      return SAT_NEG;
    end
    return v[23:0];
  endfunction

  // Switch closures {s1, s2, s3, s3n, s_tdac} for an input select
  function automatic logic [4:0] cmf_switches(input logic [1:0] sel);
    case (sel)
      CMF_IN_DIRECT: return 5'h14;
      CMF_IN_INVERTED: return 5'h12;
      CMF_IN_SHORT: return 5'h0C;
      default: return 5'h05;
    endcase
  endfunction

endpackage

// ---- hw/cmf_top.sv ----
// Contract
// RULE1: Clock-source bit picks oscillator or external clock; internal after reset.
// RULE2: Modulator clock is main clock divided by two, 50 percent duty.
// RULE3: Host disables converters before changing clock source.
// RULE4: Host keeps external clock running until switchover to internal completes.
// RULE5: Two-bit input select: direct, inverted, shorted to ground, other test DAC.
// RULE6: Two-bit gain field selects gain 4, 8, 16 or 32.
// RULE7: One-bit modulator stream taken at modulator rate, far above output rate.
// RULE8: Sinc3 decimator, decimation factor equal to oversampling ratio.
// RULE9: Both sections share one main clock and control, sampling simultaneously.
// RULE10: Three-bit field sets oversampling ratio 64 to 8192 in powers of two.
// RULE11: Subtract 24-bit offset, scale by one plus gain over 65536, round, clip.
// RULE12: Samples are 24-bit two's complement, saturating at 7FFFFF and 800000.
// RULE13: Gain codes ascend: 0 is 4, 1 is 8, 2 is 16, 3 is 32.
// RULE14: After config change discard outputs for three full decimation periods.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module cmf_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (level != DEPTH_CNT);
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // cmf_fifo

module cmf_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [cmf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cmf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [cmf_pkg::DATA_W-1:0] reg_rdata,
  // Clocking
  output logic main_clock_select,
  output logic modulator_clock,
  // Modulator bitstreams
  input wire logic mod_bit_a,
  input wire logic mod_bit_b,
  // Analog front-end controls, section A
  output logic converter_enable_a,
  output logic [1:0] current_input_select_a,
  output logic [4:0] input_switches_a,
  output logic [1:0] current_gain_select_a,
  // Analog front-end controls, section B
  output logic converter_enable_b,
  output logic [1:0] current_input_select_b,
  output logic [4:0] input_switches_b,
  output logic [1:0] current_gain_select_b
);
  import cmf_pkg::*;

  logic clk_source;
  logic [1:0] enable;
  logic [CFG_W-1:0] cfg [2];
  logic [OCAL_W-1:0] offset_correction_value [2];
  logic [GCAL_W-1:0] gain_correction_value [2];
  logic [1:0] cfg_change;
  logic [1:0] filt_clear;
  logic [1:0] mod_bit;
  logic mod_tick;
  logic signed [ACC_W-1:0] integ1 [2];
  logic signed [ACC_W-1:0] integ2 [2];
  logic signed [ACC_W-1:0] integ3 [2];
  logic signed [ACC_W-1:0] z1 [2];
  logic signed [ACC_W-1:0] z2 [2];
  logic signed [ACC_W-1:0] z3 [2];
  logic signed [ACC_W-1:0] c1 [2];
  logic signed [ACC_W-1:0] c2 [2];
  logic signed [ACC_W-1:0] c3 [2];
  logic [DEC_W-1:0] dec_cnt [2];
  logic [1:0] raw_valid;
  logic [SAMPLE_W-1:0] raw [2];
  logic [SAMPLE_W-1:0] calibrated [2];
  logic [1:0] settle [2];
  logic [1:0] pend_valid;
  logic [SAMPLE_W-1:0] pend_data [2];
  logic [1:0] overrun;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FIFO_W-1:0] fifo_in_data;
  logic push_sel;
  logic [1:0] accepted;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [3:0] fifo_level;

  // Last count of a decimation period: ratio 2^(osr+6) minus one
  function automatic logic [DEC_W-1:0] dec_last(input logic [2:0] osr);
    logic [DEC_W:0] ratio;
    ratio = (DEC_W + 1)'(1) << ({1'b0, osr} + OSR_LOG_MIN);
    return DEC_W'(ratio - 1'b1);
  endfunction

  // Scale the sinc3 output (full scale 2^(3k)) to 24-bit full scale
  function automatic logic [SAMPLE_W-1:0] normalize(input logic signed [ACC_W-1:0] v,
                                                    input logic [2:0] osr);
    logic signed [ACC_W-1:0] shifted;
    logic signed [ACC_W-1:0] dropped;
    shifted = v <<< (NORM_SHIFT_MAX - 6'(3 * osr));
    dropped = shifted >>> NORM_DROP;
    return cmf_clip({{2{dropped[ACC_W-1]}}, dropped});
  endfunction

  // Offset subtract, gain scale, round and clip
  function automatic logic [SAMPLE_W-1:0] calibrate(input logic [SAMPLE_W-1:0] s,
                                                    input logic [OCAL_W-1:0] ofs,
                                                    input logic [GCAL_W-1:0] g);
    logic signed [24:0] diff;
    logic signed [17:0] mult;
    logic signed [PROD_W-1:0] prod;
    diff = $signed({s[23], s}) - $signed({ofs[23], ofs});
    mult = GCAL_UNITY + $signed({{2{g[15]}}, g});
    prod = diff * mult;
    return cmf_clip((prod + CAL_ROUND) >>> CAL_SHIFT);
  endfunction

  assign mod_bit = {mod_bit_b, mod_bit_a};

  // Register writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_source <= CLK_SRC_INTERNAL; // RULE1
      enable <= 2'h0;
    end else if (reg_write && reg_addr == OFS_CTRL) begin
      enable <= {reg_wdata[CTRL_EN_B_BIT], reg_wdata[CTRL_EN_A_BIT]};
      // Source only switches while both converters are already off
      if (enable == 2'h0) begin // RULE3
        clk_source <= reg_wdata[CTRL_CLK_SRC_BIT]; // RULE1
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int s = 0; s < 2; s++) begin
        cfg[s] <= CFG_RST;
        offset_correction_value[s] <= '0;
        gain_correction_value[s] <= '0;
      end
    end else if (reg_write) begin
      case (reg_addr)
        OFS_CFG_A: cfg[0] <= reg_wdata[CFG_W-1:0];
        OFS_CFG_B: cfg[1] <= reg_wdata[CFG_W-1:0];
        OFS_OCAL_A: offset_correction_value[0] <= reg_wdata[OCAL_W-1:0];
        OFS_OCAL_B: offset_correction_value[1] <= reg_wdata[OCAL_W-1:0];
        OFS_GCAL_A: gain_correction_value[0] <= reg_wdata[GCAL_W-1:0];
        OFS_GCAL_B: gain_correction_value[1] <= reg_wdata[GCAL_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    cfg_change[0] = reg_write && reg_addr == OFS_CFG_A && reg_wdata[CFG_W-1:0] != cfg[0];
    cfg_change[1] = reg_write && reg_addr == OFS_CFG_B && reg_wdata[CFG_W-1:0] != cfg[1];
    filt_clear = ~enable | cfg_change; // RULE14
  end

  // Shared divide-by-two modulator clock for both sections
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      modulator_clock <= 1'b0;
    end else begin
      modulator_clock <= ~modulator_clock; // RULE2 RULE9
    end
  end

  assign mod_tick = modulator_clock; // RULE7 RULE9

  // Comb differences at the decimation instant
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      c1[s] = integ3[s] - z1[s]; // RULE8
      c2[s] = c1[s] - z2[s];
      c3[s] = c2[s] - z3[s];
    end
  end

  // Sinc3 integrators and decimation
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int s = 0; s < 2; s++) begin
        integ1[s] <= '0;
        integ2[s] <= '0;
        integ3[s] <= '0;
        z1[s] <= '0;
        z2[s] <= '0;
        z3[s] <= '0;
        dec_cnt[s] <= '0;
        raw[s] <= '0;
      end
      raw_valid <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        raw_valid[s] <= 1'b0;
        if (filt_clear[s]) begin
          integ1[s] <= '0;
          integ2[s] <= '0;
          integ3[s] <= '0;
          z1[s] <= '0;
          z2[s] <= '0;
          z3[s] <= '0;
          dec_cnt[s] <= '0;
        end else if (mod_tick) begin
          // Bit 1 counts as +1, bit 0 as -1
          integ1[s] <= integ1[s] + $signed({{(ACC_W-1){~mod_bit[s]}}, 1'b1}); // RULE7 RULE8
          integ2[s] <= integ2[s] + integ1[s];
          integ3[s] <= integ3[s] + integ2[s];
          if (dec_cnt[s] == dec_last(cfg[s][CFG_OSR_LSB +: 3])) begin // RULE10
            dec_cnt[s] <= '0;
            z1[s] <= integ3[s];
            z2[s] <= c1[s];
            z3[s] <= c2[s];
            raw[s] <= normalize(c3[s], cfg[s][CFG_OSR_LSB +: 3]); // RULE12
            raw_valid[s] <= 1'b1;
          end else begin
            dec_cnt[s] <= dec_cnt[s] + 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      calibrated[s] = calibrate(raw[s], offset_correction_value[s],
                                gain_correction_value[s]); // RULE11 RULE12
    end
  end

  // Settling discard, calibration and hand-off to the FIFO arbiter
  assign push_sel = ~pend_valid[0];
  assign fifo_in_valid = |pend_valid;
  assign fifo_in_data = {push_sel, pend_data[push_sel]};
  assign accepted[0] = fifo_in_ready && pend_valid[0];
  assign accepted[1] = fifo_in_ready && !pend_valid[0] && pend_valid[1];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int s = 0; s < 2; s++) begin
        settle[s] <= SETTLE_PERIODS;
        pend_data[s] <= '0;
      end
      pend_valid <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (filt_clear[s]) begin
          settle[s] <= SETTLE_PERIODS; // RULE14
        end else if (raw_valid[s] && settle[s] != 2'h0) begin
          settle[s] <= settle[s] - 1'b1; // RULE14
        end
        if (raw_valid[s] && settle[s] == 2'h0 && !filt_clear[s]) begin
          pend_valid[s] <= 1'b1;
          pend_data[s] <= calibrated[s]; // RULE11
        end else if (accepted[s]) begin
          pend_valid[s] <= 1'b0;
        end
      end
    end
  end

  // Overrun: a new sample replaced one the full FIFO had not taken; set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      overrun <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (raw_valid[s] && settle[s] == 2'h0 && !filt_clear[s] &&
            pend_valid[s] && !accepted[s]) begin
          overrun[s] <= 1'b1;
        end else if (reg_write && reg_addr == OFS_STATUS &&
                     reg_wdata[ST_OVERRUN_LSB + s]) begin
          overrun[s] <= 1'b0;
        end
      end
    end
  end

  cmf_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Reading the sample register pops one entry
  assign fifo_out_ready = reg_read && reg_addr == OFS_SAMPLE;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= '0;
      case (reg_addr)
        OFS_CTRL: begin
          reg_rdata[CTRL_CLK_SRC_BIT] <= clk_source;
          reg_rdata[CTRL_EN_A_BIT] <= enable[0];
          reg_rdata[CTRL_EN_B_BIT] <= enable[1];
        end
        OFS_CFG_A: reg_rdata[CFG_W-1:0] <= cfg[0];
        OFS_CFG_B: reg_rdata[CFG_W-1:0] <= cfg[1];
        OFS_OCAL_A: reg_rdata[OCAL_W-1:0] <= offset_correction_value[0];
        OFS_OCAL_B: reg_rdata[OCAL_W-1:0] <= offset_correction_value[1];
        OFS_GCAL_A: reg_rdata[GCAL_W-1:0] <= gain_correction_value[0];
        OFS_GCAL_B: reg_rdata[GCAL_W-1:0] <= gain_correction_value[1];
        OFS_STATUS: begin
          reg_rdata[ST_CLK_SRC_BIT] <= clk_source;
          reg_rdata[ST_SETTLED_LSB] <= enable[0] && settle[0] == 2'h0;
          reg_rdata[ST_SETTLED_LSB + 1] <= enable[1] && settle[1] == 2'h0;
          reg_rdata[ST_OVERRUN_LSB +: 2] <= overrun;
          reg_rdata[ST_LEVEL_LSB +: 4] <= fifo_level;
        end
        OFS_SAMPLE: begin
          reg_rdata[SMP_VALID_BIT] <= fifo_out_valid;
          reg_rdata[FIFO_W-1:0] <= fifo_out_valid ? fifo_out_data : '0;
        end
        default: ;
      endcase
    end
  end

  // Front-end control outputs, all from registers
  assign main_clock_select = clk_source; // RULE1
  assign converter_enable_a = enable[0];
  assign converter_enable_b = enable[1];
  assign current_input_select_a = cfg[0][CFG_MUX_LSB +: 2];
  assign current_input_select_b = cfg[1][CFG_MUX_LSB +: 2];
  assign input_switches_a = cmf_switches(cfg[0][CFG_MUX_LSB +: 2]); // RULE5
  assign input_switches_b = cmf_switches(cfg[1][CFG_MUX_LSB +: 2]); // RULE5
  assign current_gain_select_a = cfg[0][CFG_GAIN_LSB +: 2]; // RULE6 RULE13
  assign current_gain_select_b = cfg[1][CFG_GAIN_LSB +: 2]; // RULE6 RULE13

endmodule // cmf_top

`default_nettype wire

// ---- verification/cmf_top_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module cmf_top_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [cmf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cmf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [cmf_pkg::DATA_W-1:0] reg_rdata,
  // Clocking
  input wire logic main_clock_select,
  input wire logic modulator_clock,
  // Bitstreams
  input wire logic mod_bit_a,
  input wire logic mod_bit_b,
  // Section A
  input wire logic converter_enable_a,
  input wire logic [1:0] current_input_select_a,
  input wire logic [4:0] input_switches_a,
  input wire logic [1:0] current_gain_select_a,
  // Section B
  input wire logic converter_enable_b,
  input wire logic [1:0] current_input_select_b,
  input wire logic [4:0] input_switches_b,
  input wire logic [1:0] current_gain_select_b
);
  import cmf_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic ctrl_wr;
  logic idle;
  assign ctrl_wr = reg_write && reg_addr == OFS_CTRL;
  assign idle = !converter_enable_a && !converter_enable_b;

  // Expected switch closures {s1, s2, s3, s3n, s_tdac}
  function automatic logic [4:0] sw_exp(input logic [1:0] s);
    case (s)
      2'h0: return 5'h14;
      2'h1: return 5'h12;
      2'h2: return 5'h0C;
      default: return 5'h05;
    endcase
  endfunction

  property p_src_take;
    ctrl_wr && idle |=> main_clock_select == $past(reg_wdata[0]);
  endproperty
  property p_src_hold;
    !(ctrl_wr && idle) |=> $stable(main_clock_select);
  endproperty
  // The first edge after release still sees the reset value twice
  property p_mod_toggle;
    $past(reset_n) |-> modulator_clock != $past(modulator_clock);
  endproperty
  property p_sw_a;
    input_switches_a == sw_exp(current_input_select_a);
  endproperty
  property p_sw_b;
    input_switches_b == sw_exp(current_input_select_b);
  endproperty
  property p_cfg_a;
    reg_write && reg_addr == OFS_CFG_A |=> current_input_select_a == $past(reg_wdata[1:0])
      && current_gain_select_a == $past(reg_wdata[3:2]);
  endproperty
  property p_cfg_b;
    reg_write && reg_addr == OFS_CFG_B |=> current_input_select_b == $past(reg_wdata[1:0])
      && current_gain_select_b == $past(reg_wdata[3:2]);
  endproperty
  property p_enable;
    ctrl_wr |=> {converter_enable_b, converter_enable_a} == $past(reg_wdata[2:1]);
  endproperty
  property p_status_src;
    reg_read && reg_addr == OFS_STATUS |=> reg_rdata[0] == $past(main_clock_select);
  endproperty
  property p_sample_fmt;
    reg_read && reg_addr == OFS_SAMPLE |=> reg_rdata[30:25] == 6'h00
      && (reg_rdata[31] || reg_rdata == 32'h0);
  endproperty

  a_src_take: assert property (p_src_take) else $error("clock source not taken");
  a_src_hold: assert property (p_src_hold) else $error("clock source changed");
  a_mod_toggle: assert property (p_mod_toggle) else $error("modulator clock stuck");
  a_sw_a: assert property (p_sw_a) else $error("section a switches wrong");
  a_sw_b: assert property (p_sw_b) else $error("section b switches wrong");
  a_cfg_a: assert property (p_cfg_a) else $error("section a selects wrong");
  a_cfg_b: assert property (p_cfg_b) else $error("section b selects wrong");
  a_enable: assert property (p_enable) else $error("enables wrong");
  a_status_src: assert property (p_status_src) else $error("status source wrong");
  a_sample_fmt: assert property (p_sample_fmt) else $error("sample word malformed");

  c_src: cover property (ctrl_wr && idle && reg_wdata[0]);
  c_sample: cover property (reg_read && reg_addr == OFS_SAMPLE ##1 reg_rdata[31]);
  c_dac: cover property (reg_write && reg_addr == OFS_CFG_B && reg_wdata[1:0] == 2'h3);
endmodule // cmf_top_checker

bind cmf_top cmf_top_checker u_chk (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .main_clock_select, .modulator_clock, .mod_bit_a, .mod_bit_b,
  .converter_enable_a, .current_input_select_a, .input_switches_a, .current_gain_select_a,
  .converter_enable_b, .current_input_select_b, .input_switches_b, .current_gain_select_b);
`default_nettype wire

// ---- verification/cmf_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module cmf_top_tb_top;
  import cmf_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic main_clock_select, modulator_clock, converter_enable_a, converter_enable_b;
  logic mod_bit_a = 1'b0;
  logic mod_bit_b = 1'b0;
  logic [1:0] current_input_select_a, current_gain_select_a;
  logic [1:0] current_input_select_b, current_gain_select_b;
  logic [4:0] input_switches_a, input_switches_b;
  logic [4:0] sw_tab [4] = '{5'h14, 5'h12, 5'h0C, 5'h05};
  logic [31:0] rv;
  logic m;
  int fails = 0;
  int checked = 0;
  int n;

  always #5 mclk = ~mclk;

  cmf_top dut (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .main_clock_select, .modulator_clock, .mod_bit_a, .mod_bit_b,
    .converter_enable_a, .current_input_select_a, .input_switches_a, .current_gain_select_a,
    .converter_enable_b, .current_input_select_b, .input_switches_b, .current_gain_select_b);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Poll the fill level under a bound
  task automatic wait_level(input int lvl);
    int i;
    for (i = 0; i < 1000; i++) begin
      rd(OFS_STATUS, rv);
      if (rv[11:8] >= lvl) break;
    end
    if (i == 1000) begin
      fails++;
      $display("[FAIL] fifo level expected %0d seen %0d", lvl, rv[11:8]);
      finish_test();
    end
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("clock source", 0, main_clock_select);
    rd(OFS_STATUS, rv);
    chk("status source", 0, rv[0]);
    for (int i = 0; i < 8; i++) begin
      m = modulator_clock;
      @(posedge mclk);
      #1;
      chk("modulator clock", !m, modulator_clock);
    end
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CFG_A, 32'(s * 5));
      wr(OFS_CFG_B, 32'((3 - s) * 5));
      chk("select a", s, current_input_select_a);
      chk("switches a", sw_tab[s], input_switches_a);
      chk("gain a", s, current_gain_select_a);
      chk("select b", 3 - s, current_input_select_b);
      chk("switches b", sw_tab[3 - s], input_switches_b);
      chk("gain b", 3 - s, current_gain_select_b);
    end
    wr(OFS_CTRL, 32'h2);
    wr(OFS_CTRL, 32'h3);
    chk("source while enabled", 0, main_clock_select);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1);
    chk("external source", 1, main_clock_select);
    rd(OFS_STATUS, rv);
    chk("status external", 1, rv[0]);
    wr(OFS_CTRL, 32'h0);
    chk("internal source", 0, main_clock_select);
    rd(8'h40, rv);
    chk("unmapped read", 0, rv);
    // Full-scale streams: all ones on A, all zeros on B
    wr(OFS_CFG_A, 32'h0);
    wr(OFS_CFG_B, 32'h0);
    mod_bit_a <= 1'b1;
    mod_bit_b <= 1'b0;
    wr(OFS_CTRL, 32'h6);
    chk("enables", 2'h3, {converter_enable_b, converter_enable_a});
    // Two of the three discarded outputs are done, the third is not
    repeat (3 * 128 - 32) @(posedge mclk);
    rd(OFS_STATUS, rv);
    chk("level while settling", 0, rv[11:8]);
    chk("settled while settling", 0, rv[2:1]);
    wait_level(2);
    chk("settled flags", 3, rv[2:1]);
    rd(OFS_SAMPLE, rv);
    chk("sample a", 32'h807FFFFF, rv);
    rd(OFS_SAMPLE, rv);
    chk("sample b", 32'h81800000, rv);
    // Fill the buffer until it refuses
    wait_level(8);
    repeat (300) @(posedge mclk);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, rv);
    chk("full level", 8, rv[11:8]);
    chk("overrun", 3, rv[4:3]);
    wr(OFS_STATUS, 32'h18);
    rd(OFS_STATUS, rv);
    chk("overrun cleared", 0, rv[4:3]);
    n = 0;
    for (int i = 0; i < 12; i++) begin
      rd(OFS_SAMPLE, rv);
      if (rv[31] !== 1'b1) break;
      n++;
      chk("drained", rv[24] ? 32'h81800000 : 32'h807FFFFF, rv);
    end
    // Eight buffered plus one held sample per section
    chk("drained count", 10, n);
    chk("empty read", 0, rv);
    // Offset on A, half gain on B
    wr(OFS_OCAL_A, 32'h10);
    wr(OFS_GCAL_B, 32'h8000);
    wr(OFS_CTRL, 32'h6);
    wait_level(2);
    rd(OFS_SAMPLE, rv);
    chk("offset sample a", 32'h807FFFEF, rv);
    rd(OFS_SAMPLE, rv);
    chk("scaled sample b", 32'h81C00000, rv);
    // Ratio 128 on A: three discarded periods now take 768 cycles
    wr(OFS_CFG_A, 32'h10);
    repeat (3 * 256 - 32) @(posedge mclk);
    rd(OFS_STATUS, rv);
    chk("settling at ratio 128", 2, rv[2:1]);
    repeat (64) @(posedge mclk);
    rd(OFS_STATUS, rv);
    chk("settled at ratio 128", 3, rv[2:1]);
    finish_test();
  end
endmodule // cmf_top_tb_top
`default_nettype wire
